// ===== epw_host.sv
// host controller driving a byte-wide eeprom: reads, page writes, polling
`timescale 1ns/100ps
module epw_host #(
  parameter int FIFO_DEPTH = 32,
  parameter int WRITE_WAIT = epw_pkg::WRITE_WAIT_CYC,
  parameter bit USE_POLL = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request stream
  input wire logic req_valid,
  output logic req_ready,
  input wire epw_pkg::epw_req_t req,
  // read answer and status
  output logic rsp_valid,
  output logic [epw_pkg::DATA_W-1:0] rsp_data,
  output logic busy,
  output logic page_error,
  // memory pins
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic [epw_pkg::ADDR_W-1:0] mem_addr,
  output logic [epw_pkg::DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [epw_pkg::DATA_W-1:0] mem_dq_in
);
  localparam int REQ_W = $bits(epw_pkg::epw_req_t);
  localparam int CW = $clog2(WRITE_WAIT + 1);

  if (WRITE_WAIT < 1)
  begin
    $error("write wait must be at least one cycle");
  end

  typedef enum logic [2:0] {
    EPW_IDLE,
    EPW_READ,
    EPW_WSTROBE,
    EPW_RECOVER,
    EPW_WAIT,
    EPW_POLL
  } epw_state_t;

  typedef struct packed {
    epw_state_t state;
    logic [CW-1:0] cnt;
    epw_pkg::epw_pins_t pins;
    logic in_page;
    logic [epw_pkg::ADDR_W-1:epw_pkg::PAGE_LSB] page;
    logic [epw_pkg::DATA_W-1:0] last_data;
    logic [epw_pkg::ADDR_W-1:0] last_addr;
    logic poll_read;
    logic have_prev;
    logic prev_tog;
    logic rsp_valid;
    logic [epw_pkg::DATA_W-1:0] rsp_data;
    logic page_error;
  } epw_host_st_t;

  epw_host_st_t st, next_st;
  epw_pkg::epw_req_t cur;
  logic cur_valid, take;
  localparam epw_pkg::epw_pins_t PINS_IDLE = '{
    ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};

  epw_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(cur_valid),
    .out_ready(take),
    .out_data(cur)
  );

  // a request is taken only from idle, so cycles outside EPW_IDLE stall the fifo
  assign take = (st.state == EPW_IDLE) && cur_valid;

  always_comb
  begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.cnt = (st.cnt != '0) ? st.cnt - 1'b1 : st.cnt;
    unique case (st.state)
      EPW_IDLE:
      begin
        next_st.pins = PINS_IDLE;
        if (take)
        begin
          next_st.pins.addr = cur.addr;
          next_st.pins.ce_n = 1'b0;
          if (cur.cmd == epw_pkg::EPW_CMD_WRITE)
          begin
            // page bits must match the open page
            if (st.in_page && cur.addr[epw_pkg::ADDR_W-1:epw_pkg::PAGE_LSB]
                != st.page)
              next_st.page_error = 1'b1;
            else
              next_st.page_error = 1'b0;
            if (st.in_page)
              next_st.pins.addr[epw_pkg::ADDR_W-1:epw_pkg::PAGE_LSB] =
                st.page;
            else
              next_st.page = cur.addr[epw_pkg::ADDR_W-1:epw_pkg::PAGE_LSB];
            next_st.in_page = !cur.last;
            next_st.pins.we_n = 1'b0;
            next_st.pins.dq_out = cur.data;
            next_st.pins.dq_oe = 1'b1;
            next_st.last_data = cur.data;
            next_st.last_addr = next_st.pins.addr;
            next_st.cnt = CW'(epw_pkg::STROBE_CYC);
            next_st.state = EPW_WSTROBE;
          end
          else
          begin
            // read or poll between page loads leaves the page open
            next_st.pins.oe_n = 1'b0;
            next_st.poll_read = cur.cmd == epw_pkg::EPW_CMD_POLL;
            next_st.cnt = CW'(epw_pkg::READ_CYC);
            next_st.state = EPW_READ;
          end
        end
      end
      EPW_READ, EPW_POLL:
      begin
        if (st.cnt <= 1)
        begin
          next_st.rsp_valid = st.state == EPW_READ;
          next_st.rsp_data = mem_dq_in;
          next_st.pins = PINS_IDLE;
          next_st.cnt = CW'(epw_pkg::RELEASE_CYC);
          next_st.poll_read = 1'b0;
          next_st.state = EPW_RECOVER;
          if (st.state == EPW_POLL)
          begin
            // done when bit 7 matches the written data and bit 6 stopped toggling
            next_st.have_prev = 1'b1;
            next_st.prev_tog = mem_dq_in[epw_pkg::TOGGLE_BIT];
            if (mem_dq_in[epw_pkg::POLL_BIT]
                == st.last_data[epw_pkg::POLL_BIT]
                && st.have_prev
                && mem_dq_in[epw_pkg::TOGGLE_BIT] == st.prev_tog)
              next_st.have_prev = 1'b0;
            else
              // strobes rise between polls: each is its own read cycle
              next_st.poll_read = 1'b1;
          end
        end
      end
      EPW_WSTROBE:
      begin
        if (st.cnt <= 1)
        begin
          next_st.pins.we_n = 1'b1;
          next_st.pins.ce_n = 1'b1;
          if (st.in_page)
          begin
            next_st.cnt = CW'(epw_pkg::STROBE_CYC);
            next_st.state = EPW_RECOVER;
          end
          else if (USE_POLL)
          begin
            next_st.have_prev = 1'b0;
            next_st.cnt = CW'(epw_pkg::STROBE_CYC);
            next_st.state = EPW_RECOVER;
            next_st.poll_read = 1'b1;
          end
          else
          begin
            next_st.cnt = CW'(WRITE_WAIT);
            next_st.state = EPW_WAIT;
          end
        end
      end
      EPW_RECOVER:
      begin
        next_st.pins.dq_oe = 1'b0;
        if (st.cnt <= 1)
        begin
          // closing write or unfinished poll: read the same byte again
          if (st.poll_read && !st.in_page)
          begin
            next_st.pins.ce_n = 1'b0;
            next_st.pins.oe_n = 1'b0;
            next_st.pins.addr = st.last_addr;
            next_st.cnt = CW'(epw_pkg::READ_CYC + epw_pkg::RELEASE_CYC);
            next_st.state = EPW_POLL;
          end
          else
          begin
            next_st.poll_read = 1'b0;
            next_st.state = EPW_IDLE;
          end
        end
      end
      EPW_WAIT:
      begin
        next_st.pins.dq_oe = 1'b0;
        if (st.cnt <= 1)
          next_st.state = EPW_IDLE;
      end
      default:
        next_st.state = EPW_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.pins <= PINS_IDLE;
    end
    else
      st <= next_st;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= next_st.state != EPW_IDLE || next_st.in_page;
  end

  assign mem_ce_n = st.pins.ce_n;
  assign mem_oe_n = st.pins.oe_n;
  assign mem_we_n = st.pins.we_n;
  assign mem_addr = st.pins.addr;
  assign mem_dq_out = st.pins.dq_out;
  assign mem_dq_oe = st.pins.dq_oe;
  assign rsp_valid = st.rsp_valid;
  assign rsp_data = st.rsp_data;
  assign page_error = st.page_error;
endmodule

// ===== epw_pkg.sv
// package: pin bundles, timing constants and commands for the eeprom host
package epw_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_BYTES = 64;
  localparam int CLK_PERIOD_NS = 50;
  // internal write time, max, in microseconds
  localparam int INTERNAL_WRITE_TIME_US = 5000;
  localparam int WRITE_WAIT_CYC =
    (INTERNAL_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // read access time, max, in nanoseconds, slowest grade
  localparam int READ_ACCESS_NS = 120;
  localparam int READ_CYC =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strobe pulse width, min, in nanoseconds
  localparam int STROBE_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // release delay before the bus may be driven again
  localparam int OUTPUT_RELEASE_DELAY_NS = 30;
  localparam int RELEASE_CYC =
    (OUTPUT_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;

  typedef enum logic [1:0] {
    EPW_CMD_READ,
    EPW_CMD_WRITE,
    EPW_CMD_POLL
  } epw_cmd_t;

  // user request: command, address, data, last byte of a page
  typedef struct packed {
    epw_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic last;
  } epw_req_t;

  // memory pins, strobes active low
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } epw_pins_t;

endpackage

// ===== epw_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module epw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin
    $error("depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [WIDTH-1:0] rdata;
    logic rvalid;
    logic rdy;
  } epw_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  epw_fifo_st_t st, next_st;
  logic full, empty, push, pop;

  // output register holds one word; memory refills it when drained
  assign full = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
  assign empty = st.wp == st.rp;
  // ready is registered so that it leaves the block straight from a flop
  assign in_ready = st.rdy;
  assign push = in_valid && !full;
  assign pop = !empty && (!st.rvalid || out_ready);
  assign out_valid = st.rvalid;
  assign out_data = st.rdata;

  always_comb
  begin
    next_st = st;
    if (push)
      next_st.wp = st.wp + 1'b1;
    if (pop)
    begin
      next_st.rp = st.rp + 1'b1;
      next_st.rdata = mem[st.rp[AW-1:0]];
      next_st.rvalid = 1'b1;
    end
    else if (out_ready)
      next_st.rvalid = 1'b0;
    next_st.rdy = (next_st.wp - next_st.rp) != (AW+1)'(DEPTH);
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[st.wp[AW-1:0]] <= in_data;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st <= '{rdy: 1'b1, default: '0};
    else
      st <= next_st;
  end
endmodule

// ===== epw_host_monitor.sv
// checker: pin-level timing of the eeprom host
`timescale 1ns/100ps
module epw_host_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request and answer
  input wire logic req_valid,
  input wire logic req_ready,
  input wire epw_pkg::epw_req_t req,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic busy,
  input wire logic page_error,
  // memory pins
  input wire logic mem_ce_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic [12:0] mem_addr,
  input wire logic [7:0] mem_dq_out,
  input wire logic mem_dq_oe,
  input wire logic [7:0] mem_dq_in
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic open;
  logic [6:0] pg;
  // page closes at the first read, which is how polling starts
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      open <= 1'b0;
      pg <= 7'h00;
    end
    else if (!mem_we_n && !mem_ce_n)
    begin
      open <= 1'b1;
      pg <= mem_addr[12:6];
    end
    else if (!mem_oe_n)
      open <= 1'b0;
  end
  a_read_hold: assert property ($fell(mem_oe_n) |->
    (!mem_oe_n && !mem_ce_n && mem_we_n) [*3])
    else $error("read strobes too short");
  a_no_contend: assert property (!mem_oe_n |-> !mem_dq_oe)
    else $error("host drives data during read");
  a_bus_release: assert property ($rose(mem_oe_n) |->
    !mem_dq_oe ##1 !mem_dq_oe)
    else $error("bus driven before release");
  a_write_hold: assert property ($rose(mem_we_n) |->
    $stable(mem_addr) && $stable(mem_dq_out) && mem_dq_oe)
    else $error("write address or data moved");
  a_write_shape: assert property ($fell(mem_we_n) |->
    !mem_ce_n && mem_oe_n && mem_dq_oe)
    else $error("bad write strobe set");
  a_write_end: assert property ($fell(mem_we_n) |->
    ##[1:4] $rose(mem_we_n))
    else $error("write strobe stuck low");
  a_page_fixed: assert property ($fell(mem_we_n) && open |->
    mem_addr[12:6] == pg)
    else $error("page bits changed in page");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer pulse too long");
endmodule

bind epw_host epw_host_monitor u_mon (.mclk, .rst, .req_valid, .req_ready,
  .req, .rsp_valid, .rsp_data, .busy, .page_error, .mem_ce_n, .mem_oe_n,
  .mem_we_n, .mem_addr, .mem_dq_out, .mem_dq_oe, .mem_dq_in);

// ===== epw_eeprom_model.sv
// behavioural byte-wide eeprom with self-timed write and polling
`timescale 1ns/100ps
module epw_eeprom_model #(
  parameter int TWR = 200
) (
  // clock samples the pins and times the internal write
  input wire logic mclk,
  // pins from the host
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [12:0] addr,
  input wire logic [7:0] dq,
  // data to the host
  output logic [7:0] dq_in
);
  logic [7:0] mem [0:8191];
  logic [7:0] last = 8'h00;
  logic [7:0] q = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [12:0] wa = 13'h0000;
  logic [15:0] cnt = 16'h0000;
  logic tog = 1'b0;
  logic wp = 1'b0;
  logic rp = 1'b0;
  wire rd = !ce_n && !oe_n && we_n;
  wire wr = !ce_n && !we_n && oe_n;
  // released bus shows a changing pattern, never a held value
  assign dq_in = !rd ? ~q : (cnt != 0) ?
    {~last[7], tog, last[5:0]} : mem[addr];
  always @(posedge mclk)
  begin
    q <= dq_in;
    wp <= wr;
    rp <= rd;
    if (wr)
    begin
      wa <= addr;
      wd <= dq;
    end
    // each load restarts the timer; reads between loads do not abort
    if (wp && !wr)
    begin
      mem[wa] <= wd;
      last <= wd;
      cnt <= TWR[15:0];
    end
    else if (cnt != 0)
      cnt <= cnt - 16'h0001;
    if (rp && !rd && cnt != 0)
      tog <= ~tog;
  end
endmodule

// ===== test_eeprom_page_write_poll_port.sv
// testbench: eeprom host against the eeprom model
`timescale 1ns/100ps
module test_eeprom_page_write_poll_port;
  localparam int TWR = 200;
  logic mclk, rst, req_valid, req_ready, rsp_valid, busy, page_error;
  logic mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe;
  epw_pkg::epw_req_t req;
  logic [7:0] rsp_data, mem_dq_out, mem_dq_in;
  logic [12:0] mem_addr;
  logic [7:0] rq[$];
  logic w_valid, w_ready, w_rvalid, w_busy, w_err;
  logic w_ce_n, w_oe_n, w_we_n, w_dq_oe;
  logic [7:0] w_rdata, w_dq_out, w_dq_in;
  logic [12:0] w_addr;
  int mismatches = 0;
  int n_checks = 0;
  epw_host u_dut (.mclk, .rst, .req_valid, .req_ready, .req, .rsp_valid,
    .rsp_data, .busy, .page_error, .mem_ce_n, .mem_oe_n, .mem_we_n,
    .mem_addr, .mem_dq_out, .mem_dq_oe, .mem_dq_in);
  epw_eeprom_model #(.TWR(TWR)) u_mem (.mclk, .ce_n(mem_ce_n),
    .oe_n(mem_oe_n), .we_n(mem_we_n), .addr(mem_addr),
    .dq(mem_dq_out), .dq_in(mem_dq_in));
  // second host uses the fixed wait instead of polling
  epw_host #(.USE_POLL(1'b0), .WRITE_WAIT(TWR)) u_dut_wait (.mclk, .rst,
    .req_valid(w_valid), .req_ready(w_ready), .req, .rsp_valid(w_rvalid),
    .rsp_data(w_rdata), .busy(w_busy), .page_error(w_err),
    .mem_ce_n(w_ce_n), .mem_oe_n(w_oe_n), .mem_we_n(w_we_n),
    .mem_addr(w_addr), .mem_dq_out(w_dq_out), .mem_dq_oe(w_dq_oe),
    .mem_dq_in(w_dq_in));
  epw_eeprom_model #(.TWR(TWR)) u_mem_wait (.mclk, .ce_n(w_ce_n),
    .oe_n(w_oe_n), .we_n(w_we_n), .addr(w_addr),
    .dq(w_dq_out), .dq_in(w_dq_in));
  always #25 mclk = ~mclk;
  always @(posedge mclk)
    if (rsp_valid === 1'b1)
      rq.push_back(rsp_data);
  task chk(string s, logic [12:0] e, logic [12:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task push(epw_pkg::epw_cmd_t c, logic [12:0] a, logic [7:0] d, logic l);
    @(negedge mclk);
    req_valid = 1'b1;
    req = '{c, a, d, l};
    do @(posedge mclk); while (req_ready !== 1'b1);
  endtask
  // drop valid, then wait for ten quiet cycles
  task idle(output int t);
    int n;
    n = 0;
    t = 0;
    @(negedge mclk);
    req_valid = 1'b0;
    while (t < 20000 && n < 10)
    begin
      @(posedge mclk);
      t++;
      n = (busy === 1'b0) ? n + 1 : 0;
    end
    if (n < 10)
    begin
      mismatches++;
      $display("[FAIL] idle expected 10 quiet cycles seen %0d", n);
    end
  endtask
  task rd_chk(logic [12:0] a, logic [7:0] e);
    int t;
    push(epw_pkg::EPW_CMD_READ, a, 8'h00, 1'b1);
    idle(t);
    chk("read size", 13'd1, rq.size());
    if (rq.size() > 0)
      chk("read data", e, rq.pop_front());
  endtask
  task t_reset;
    chk("strobes", 13'h0007, {mem_ce_n, mem_oe_n, mem_we_n});
    chk("idle", 13'h0001, {busy, mem_dq_oe, req_ready});
  endtask
  task t_byte;
    int t;
    push(epw_pkg::EPW_CMD_WRITE, 13'h0105, 8'ha5, 1'b1);
    idle(t);
    chk("write waits", 13'h0001, t >= TWR);
    rd_chk(13'h0105, 8'ha5);
  endtask
  task t_page;
    int t;
    push(epw_pkg::EPW_CMD_WRITE, 13'h0240, 8'h10, 1'b0);
    push(epw_pkg::EPW_CMD_WRITE, 13'h0241, 8'h11, 1'b0);
    push(epw_pkg::EPW_CMD_WRITE, 13'h0482, 8'h12, 1'b1);
    idle(t);
    chk("page error", 13'h0001, page_error);
    rd_chk(13'h0240, 8'h10);
    rd_chk(13'h0241, 8'h11);
    rd_chk(13'h0242, 8'h12);
  endtask
  task t_fifo;
    int n;
    int t;
    n = 0;
    push(epw_pkg::EPW_CMD_WRITE, 13'h0300, 8'h77, 1'b1);
    push(epw_pkg::EPW_CMD_POLL, 13'h0300, 8'h00, 1'b1);
    for (int i = 0; i < 40; i++)
    begin
      @(negedge mclk);
      if (req_ready !== 1'b1)
        break;
      req = '{epw_pkg::EPW_CMD_READ, 13'h0300, 8'h00, 1'b1};
      @(posedge mclk);
      n++;
    end
    idle(t);
    chk("fifo filled", 13'h0001, n >= 32);
    // the poll command is answered as well
    chk("answers", 13'(n + 1), 13'(rq.size()));
    while (rq.size() > 0)
      chk("queued read", 13'h0077, rq.pop_front());
  endtask
  // a read queued behind a write must wait out the write and see new data
  task t_wait;
    int t;
    t = 0;
    @(negedge mclk);
    w_valid = 1'b1;
    req = '{epw_pkg::EPW_CMD_WRITE, 13'h0033, 8'h5a, 1'b1};
    @(negedge mclk);
    req = '{epw_pkg::EPW_CMD_READ, 13'h0033, 8'h00, 1'b1};
    @(negedge mclk);
    w_valid = 1'b0;
    while (t < 1000 && w_rvalid !== 1'b1)
    begin
      @(posedge mclk);
      t++;
    end
    chk("wait span", 13'h0001, t >= TWR);
    chk("wait read", 13'h005a, w_rdata);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    finish_test;
  end
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    w_valid = 1'b0;
    req = '0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_reset;
    t_byte;
    t_page;
    t_fifo;
    t_wait;
    finish_test;
  end
endmodule
